// ---- typec_port_regs.svh ----
// constants for the type-c port control block
`ifndef TYPEC_PORT_REGS_SVH
`define TYPEC_PORT_REGS_SVH
`define ACC_NONE        3'h0
`define ACC_AUDIO       3'h4
`define ACC_DBG_UFP     3'h6
`define ACC_DBG_DFP     3'h7
`define CUR_DEFAULT     2'h0
`define CUR_MEDIUM      2'h1
`define CUR_HIGH        2'h2
`define TOGGLE_NS       100000
`define CLK_NS          100
`define TOGGLE_CYC      ((`TOGGLE_NS + `CLK_NS - 1) / `CLK_NS)
`define ADDR_BIT6_RST   1'b0
`endif

// ---- typec_port_pkg.sv ----
// types shared by the type-c port control block
package typec_port_pkg;
  typedef enum logic [1:0] {TERM_OPEN, TERM_RA, TERM_RD, TERM_RP} cc_term_t;
  typedef enum logic [1:0] {TRI_LOW, TRI_HIGH, TRI_FLOAT} tri_level_t;
  typedef struct packed {
    cc_term_t cc1;
    cc_term_t cc2;
  } cc_sense_t;
endpackage

// ---- cable_supply_ctrl.sv ----
// active-cable supply switch with fault latching
`timescale 1ns/1ps
`include "typec_port_regs.svh"
module cable_supply_ctrl (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_i2c_mode,     // 1 = register control
  input  wire logic i_attached_src, // attached as source, sink seen
  input  wire logic i_ra_unused,    // ra on the unused channel pin
  input  wire logic i_overcurrent,  // supply current limit tripped
  input  wire logic i_fault_clear,  // host clears the fault flag
  output logic      o_supply_on,
  output logic      o_fault_flag
);
  logic on_q, on_d;
  logic flt_q, flt_d;
  logic lock_q, lock_d;             // gpio lockout until reattach

  // next value of switch, flag and lockout
  always_comb begin
    flt_d  = flt_q;
    lock_d = lock_q;
    if (i_overcurrent && on_q && i_i2c_mode) begin
      flt_d = 1'b1;
    end else if (i_fault_clear) begin
      flt_d = 1'b0;
    end
    if (i_overcurrent && on_q && !i_i2c_mode) begin
      lock_d = 1'b1;
    end else if (!i_attached_src) begin
      lock_d = 1'b0;                 // cleared by detach
    end
    // on only as attached source with ra, off on detach or fault
    on_d = i_attached_src && i_ra_unused && !flt_d && !lock_d && !i_overcurrent;
  end

  // registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_q   <= 1'b0;
      flt_q  <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      on_q   <= on_d;
      flt_q  <= flt_d;
      lock_q <= lock_d;
    end
  end

  assign o_supply_on  = on_q;
  assign o_fault_flag = flt_q;

  property p_fault_holds_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      flt_q |-> !on_q;
  endproperty
  a_fault_holds_off: assert property (p_fault_holds_off) else $error("supply on during fault");
  property p_lock_holds_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      lock_q |-> !on_q;
  endproperty
  a_lock_holds_off: assert property (p_lock_holds_off) else $error("supply back on before reattach");
  property p_on_needs_src;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      on_q |-> $past(i_attached_src) && $past(i_ra_unused);
  endproperty
  a_on_needs_src: assert property (p_on_needs_src) else $error("supply on without ra and source attach");
endmodule

// ---- typec_cc_port_ctrl.sv ----
// port control: attach, accessories, cable supply and open-drain outputs
`timescale 1ns/1ps
`include "typec_port_regs.svh"
module typec_cc_port_ctrl (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire typec_port_pkg::cc_sense_t  i_cc_sense,          // terminations seen on cc pins
  input  wire typec_port_pkg::tri_level_t i_role_pin,          // low sink, float dual, high source
  input  wire typec_port_pkg::tri_level_t i_bus_select_pin,    // float gpio, high/low i2c
  input  wire logic                  i_bus_power_sense_pin,    // bus supply present
  input  wire logic                  i_port_enable_n,          // high disables the port
  input  wire logic                  i_main_supply_rail,       // main supply good
  input  wire logic [1:0]            i_rp_level,               // advertised current from rp
  input  wire logic                  i_cable_overcurrent,      // cable supply current limit
  input  wire logic                  i_fault_clear,            // host write clears supply fault
  input  wire logic                  i_int_clear,              // host write clears pending
  output logic                       o_current_level_out_a_oe_n,
  output logic                       o_current_level_out_b_oe_n,
  output logic                       o_audio_detect_out_oe_n,  // also interrupt in i2c mode
  output logic                       o_attach_ident_out_oe_n,
  output logic                       o_cable_supply_fault_n_oe_n,
  output logic                       o_current_level_out_a_o,
  output logic                       o_current_level_out_b_o,
  output logic                       o_audio_detect_out_o,
  output logic                       o_attach_ident_out_o,
  output logic                       o_cable_supply_fault_n_o,
  output logic                       o_cable_supply_on,        // supply switch enable
  output logic                       o_cable_on_cc2,           // supply onto cc2 when set
  output logic                       o_present_source,         // rp when set, else rd
  output logic                       o_i2c_mode,
  output logic                       o_addr_bit6,
  output logic [2:0]                 o_accessory_status,
  output logic                       o_int_pending
);
  typedef enum logic [2:0] {ST_SHUTDOWN, ST_UNATT_SNK, ST_UNATT_SRC, ST_ATT_SNK,
                            ST_ATT_SRC, ST_AUDIO, ST_DEBUG} port_state_t;

  port_state_t      st_q, st_d;
  logic [15:0]      tog_q, tog_d;     // dual-role toggle timer
  logic [2:0]       acc_q, acc_d;     // accessory status
  logic [1:0]       cur_q, cur_d;     // detected current level
  logic             pend_q, pend_d;   // interrupt pending
  logic             i2c_q, i2c_d;     // control mode
  logic             a6_q, a6_d;       // address bit 6
  logic             dual_q, dual_d;   // dual-role sampled
  logic             src_only_q, src_only_d;
  logic             cc2_q, cc2_d;     // cable supply onto cc2
  logic             od_a_q, od_b_q, od_c_q, od_id_q, od_f_q; // pull-low requests
  logic             od_a_d, od_b_d, od_c_d, od_id_d, od_f_d;
  logic             sup_on, sup_flt, pres_q, pres_d; // pres: pull-ups shown, registered
  logic             active, disable_req;
  logic             rd_both, rp_both, ra_both, rd_one, rp_one, ra_cc1, ra_cc2;

  // terminations decode
  always_comb begin
    rd_both = i_cc_sense.cc1 == typec_port_pkg::TERM_RD && i_cc_sense.cc2 == typec_port_pkg::TERM_RD;
    rp_both = i_cc_sense.cc1 == typec_port_pkg::TERM_RP && i_cc_sense.cc2 == typec_port_pkg::TERM_RP;
    ra_both = i_cc_sense.cc1 == typec_port_pkg::TERM_RA && i_cc_sense.cc2 == typec_port_pkg::TERM_RA;
    rd_one  = (i_cc_sense.cc1 == typec_port_pkg::TERM_RD) != (i_cc_sense.cc2 == typec_port_pkg::TERM_RD);
    rp_one  = (i_cc_sense.cc1 == typec_port_pkg::TERM_RP) != (i_cc_sense.cc2 == typec_port_pkg::TERM_RP);
    ra_cc1  = i_cc_sense.cc1 == typec_port_pkg::TERM_RA;
    ra_cc2  = i_cc_sense.cc2 == typec_port_pkg::TERM_RA;
    disable_req = i_port_enable_n || !i_main_supply_rail;
  end

  // port state machine
  always_comb begin
    st_d       = st_q;
    tog_d      = tog_q;
    acc_d      = acc_q;
    cur_d      = cur_q;
    i2c_d      = i2c_q;
    a6_d       = a6_q;
    dual_d     = dual_q;
    src_only_d = src_only_q;
    cc2_d      = cc2_q;
    case (st_q)
      ST_SHUTDOWN: begin
        acc_d = `ACC_NONE;
        if (!disable_req) begin
          st_d       = ST_UNATT_SNK;
          dual_d     = i_role_pin == typec_port_pkg::TRI_FLOAT;
          src_only_d = i_role_pin == typec_port_pkg::TRI_HIGH;
          i2c_d      = i_bus_select_pin != typec_port_pkg::TRI_FLOAT;
          a6_d       = i_bus_select_pin == typec_port_pkg::TRI_HIGH;
          tog_d      = '0;
        end
      end
      ST_UNATT_SNK: begin
        tog_d = tog_q + 16'h0001;
        if (src_only_q) begin
          st_d = ST_UNATT_SRC;
        end else if (rp_both && i_bus_power_sense_pin) begin
          st_d  = ST_DEBUG;
          acc_d = `ACC_DBG_UFP;
        end else if (rp_one && i_bus_power_sense_pin) begin
          st_d  = ST_ATT_SNK;
          cur_d = i_rp_level;
        end else if (ra_both) begin
          st_d  = ST_AUDIO;
          acc_d = `ACC_AUDIO;
        end else if (dual_q && tog_q >= 16'(`TOGGLE_CYC)) begin
          st_d  = ST_UNATT_SRC;
          tog_d = '0;
        end
      end
      ST_UNATT_SRC: begin
        tog_d = tog_q + 16'h0001;
        if (rd_both) begin
          st_d  = ST_DEBUG;
          acc_d = `ACC_DBG_DFP;
        end else if (rd_one && !i_bus_power_sense_pin) begin
          st_d  = ST_ATT_SRC;
          cc2_d = ra_cc2;
        end else if (ra_both) begin
          st_d  = ST_AUDIO;
          acc_d = `ACC_AUDIO;
        end else if (dual_q && tog_q >= 16'(`TOGGLE_CYC)) begin
          st_d  = ST_UNATT_SNK;
          tog_d = '0;
        end
      end
      ST_ATT_SNK: begin
        cur_d = i_rp_level;
        if (!i_bus_power_sense_pin) begin
          st_d = ST_UNATT_SNK;
        end
      end
      ST_ATT_SRC: begin
        if (!rd_one && !rd_both) begin
          st_d = ST_UNATT_SRC;
        end
      end
      ST_AUDIO, ST_DEBUG: begin
        if (!ra_both && !rd_both && !rp_both) begin
          st_d  = src_only_q ? ST_UNATT_SRC : ST_UNATT_SNK;
          acc_d = `ACC_NONE;
        end
      end
      default: st_d = ST_SHUTDOWN;
    endcase
    if (disable_req) begin
      st_d = ST_SHUTDOWN;
    end
    if (st_d == ST_UNATT_SNK || st_d == ST_UNATT_SRC) begin
      cur_d = `CUR_DEFAULT;
    end
  end

  // state registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q       <= ST_SHUTDOWN;
      tog_q      <= '0;
      acc_q      <= `ACC_NONE;
      cur_q      <= `CUR_DEFAULT;
      i2c_q      <= 1'b0;
      a6_q       <= `ADDR_BIT6_RST;
      dual_q     <= 1'b0;
      src_only_q <= 1'b0;
      cc2_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      tog_q      <= tog_d;
      acc_q      <= acc_d;
      cur_q      <= cur_d;
      i2c_q      <= i2c_d;
      a6_q       <= a6_d;
      dual_q     <= dual_d;
      src_only_q <= src_only_d;
      cc2_q      <= cc2_d;
    end
  end

  // cable supply switch
  cable_supply_ctrl cable_supply_ctrl_inst (
    .i_core_clk     (i_core_clk),
    .i_rst_n        (i_rst_n),
    .i_i2c_mode     (i2c_q),
    .i_attached_src (st_q == ST_ATT_SRC),
    .i_ra_unused    (cc2_q ? ra_cc2 : ra_cc1),
    .i_overcurrent  (i_cable_overcurrent),
    .i_fault_clear  (i_fault_clear),
    .o_supply_on    (sup_on),
    .o_fault_flag   (sup_flt)
  );

  // interrupt pending and open-drain pull requests
  always_comb begin
    active = st_q == ST_ATT_SNK || st_q == ST_ATT_SRC || st_q == ST_AUDIO || st_q == ST_DEBUG;
    pend_d = pend_q;
    if (i2c_q && (acc_d != acc_q || cur_d != cur_q || (sup_flt && !od_f_q)
        || (st_d == ST_ATT_SNK || st_d == ST_ATT_SRC || st_d == ST_AUDIO || st_d == ST_DEBUG) != active)) begin
      pend_d = 1'b1;
    end else if (i_int_clear) begin
      pend_d = 1'b0;
    end
    od_id_d = st_q == ST_ATT_SRC;
    od_a_d  = !i2c_q && st_q == ST_ATT_SNK && cur_q != `CUR_DEFAULT;
    od_b_d  = !i2c_q && st_q == ST_ATT_SNK && cur_q == `CUR_HIGH;
    od_c_d  = i2c_q ? pend_d : (st_q == ST_AUDIO);
    od_f_d  = sup_flt;
    pres_d  = st_d == ST_UNATT_SRC || st_d == ST_ATT_SRC; // rp only while acting as source
  end

  // output registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q  <= 1'b0;
      od_a_q  <= 1'b0;
      od_b_q  <= 1'b0;
      od_c_q  <= 1'b0;
      od_id_q <= 1'b0;
      od_f_q  <= 1'b0;
      pres_q  <= 1'b0;
    end else begin
      pend_q  <= pend_d;
      od_a_q  <= od_a_d;
      od_b_q  <= od_b_d;
      od_c_q  <= od_c_d;
      od_id_q <= od_id_d;
      od_f_q  <= od_f_d;
      pres_q  <= pres_d;
    end
  end

  // open drain: data always low, enable low only while pulling
  assign o_current_level_out_a_o     = 1'b0;
  assign o_current_level_out_b_o     = 1'b0;
  assign o_audio_detect_out_o        = 1'b0;
  assign o_attach_ident_out_o        = 1'b0;
  assign o_cable_supply_fault_n_o    = 1'b0;
  assign o_current_level_out_a_oe_n  = !od_a_q;
  assign o_current_level_out_b_oe_n  = !od_b_q;
  assign o_audio_detect_out_oe_n     = !od_c_q;
  assign o_attach_ident_out_oe_n     = !od_id_q;
  assign o_cable_supply_fault_n_oe_n = !od_f_q;
  assign o_cable_supply_on           = sup_on;
  assign o_cable_on_cc2              = cc2_q;
  assign o_present_source            = pres_q;
  assign o_i2c_mode                  = i2c_q;
  assign o_addr_bit6                 = a6_q;
  assign o_accessory_status          = acc_q;
  assign o_int_pending               = pend_q;

  property p_dbg_src;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_q == ST_UNATT_SRC && rd_both && !disable_req) |=> acc_q == `ACC_DBG_DFP;
  endproperty
  a_dbg_src: assert property (p_dbg_src) else $error("rd debug not reported");
  property p_dbg_snk;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_q == ST_UNATT_SNK && !src_only_q && rp_both && i_bus_power_sense_pin && !disable_req)
      |=> acc_q == `ACC_DBG_UFP;
  endproperty
  a_dbg_snk: assert property (p_dbg_snk) else $error("rp debug not reported");
  property p_shutdown;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      disable_req |=> st_q == ST_SHUTDOWN ##1 (!o_present_source && !o_cable_supply_on);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");
  property p_int_low;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i2c_q && pend_d) |=> !o_audio_detect_out_oe_n && pend_q;
  endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt not pulled low");
  property p_int_release;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i2c_q && !pend_q && !pend_d) |=> o_audio_detect_out_oe_n;
  endproperty
  a_int_release: assert property (p_int_release) else $error("interrupt not released");
  property p_unatt_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_q == ST_UNATT_SNK || st_q == ST_UNATT_SRC) ##1 (st_q != ST_ATT_SRC) |-> !o_cable_supply_on;
  endproperty
  a_unatt_off: assert property (p_unatt_off) else $error("cable supply on while unattached");
  property p_snk_detach;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_q == ST_ATT_SNK && !i_bus_power_sense_pin) |=> st_q != ST_ATT_SNK;
  endproperty
  a_snk_detach: assert property (p_snk_detach) else $error("sink kept after bus loss");
  property p_ident;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      st_q == ST_ATT_SRC |=> !o_attach_ident_out_oe_n;
  endproperty
  a_ident: assert property (p_ident) else $error("ident not pulled on source attach");
  c_att_src: cover property (@(posedge i_core_clk) st_q == ST_ATT_SRC && o_cable_supply_on);
  c_att_snk: cover property (@(posedge i_core_clk) st_q == ST_ATT_SNK && cur_q == `CUR_HIGH);
  c_debug:   cover property (@(posedge i_core_clk) st_q == ST_DEBUG);
  c_fault:   cover property (@(posedge i_core_clk) sup_flt);
endmodule

// ---- port_partner.sv ----
// model of the port partner: terminations on the cc pins, bus supply and cable load
`timescale 1ns/1ps
module port_partner (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_present_source, // device shows pull-ups when set
  output typec_port_pkg::cc_sense_t o_cc_sense,
  output logic                      o_bus_power,
  output logic [1:0]                o_rp_level,
  output logic                      o_overcurrent
);
  logic vbus_q; // bus supply the partner offers while it acts as a source
  initial begin
    o_cc_sense    = {typec_port_pkg::TERM_OPEN, typec_port_pkg::TERM_OPEN};
    o_rp_level    = 2'h0;
    o_overcurrent = 1'b0;
    vbus_q        = 1'b0;
  end
  // a source partner only powers the bus while the device presents pull-downs
  always_comb begin
    o_bus_power = vbus_q & ~i_present_source;
  end
  // plug, change or unplug what sits on the cc pins, just after a falling edge
  task automatic set(input typec_port_pkg::cc_term_t c1, c2, input logic vbus, input logic [1:0] lvl);
    @(negedge i_core_clk);
    o_cc_sense = {c1, c2};
    vbus_q     = vbus;
    o_rp_level = lvl;
  endtask
  // active cable draws more than the supply allows while set
  task automatic oc(input logic v);
    @(negedge i_core_clk);
    o_overcurrent = v;
  endtask
endmodule

// ---- typec_cc_port_ctrl_tb.sv ----
// self-checking bench for the type-c port control block
`timescale 1ns/1ps
`include "typec_port_regs.svh"
module typec_cc_port_ctrl_tb;
  localparam int flt = 0, ident = 1, aud = 2, cur_b = 3, cur_a = 4, sup = 5, src = 6, accs = 7, pnd = 8;
  logic                       i_core_clk = 1'b0;
  logic                       i_rst_n    = 1'b0;
  typec_port_pkg::tri_level_t role_pin   = typec_port_pkg::TRI_LOW;
  typec_port_pkg::tri_level_t sel_pin    = typec_port_pkg::TRI_FLOAT;
  logic                       en_n       = 1'b1;
  logic                       main_ok    = 1'b1;
  logic                       fault_clr  = 1'b0;
  logic                       int_clr    = 1'b0;
  typec_port_pkg::cc_sense_t  cc_sense;
  logic                       bus_pwr, over_cur, supply_on, on_cc2, pres_src, i2c_mode, bit6, pend;
  logic [1:0]                 rp_lvl;
  logic [4:0]                 oe_n;      // cur_a, cur_b, audio, ident, fault
  logic [4:0]                 od_o;      // driven levels of the same pins
  logic [4:0]                 pins;      // wire levels with board pull-ups
  logic [2:0]                 acc;
  int                         err_count = 0;
  int                         checked   = 0;
  int                         cycles    = 0;
  // released pins float up, a pulled pin shows its driven level
  assign pins = oe_n | od_o;
  always #50 i_core_clk = ~i_core_clk;
  typec_cc_port_ctrl typec_cc_port_ctrl_inst (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cc_sense(cc_sense), .i_role_pin(role_pin),
    .i_bus_select_pin(sel_pin), .i_bus_power_sense_pin(bus_pwr), .i_port_enable_n(en_n),
    .i_main_supply_rail(main_ok), .i_rp_level(rp_lvl), .i_cable_overcurrent(over_cur),
    .i_fault_clear(fault_clr), .i_int_clear(int_clr),
    .o_current_level_out_a_oe_n(oe_n[4]), .o_current_level_out_b_oe_n(oe_n[3]),
    .o_audio_detect_out_oe_n(oe_n[2]), .o_attach_ident_out_oe_n(oe_n[1]),
    .o_cable_supply_fault_n_oe_n(oe_n[0]), .o_current_level_out_a_o(od_o[4]),
    .o_current_level_out_b_o(od_o[3]), .o_audio_detect_out_o(od_o[2]), .o_attach_ident_out_o(od_o[1]),
    .o_cable_supply_fault_n_o(od_o[0]), .o_cable_supply_on(supply_on), .o_cable_on_cc2(on_cc2),
    .o_present_source(pres_src), .o_i2c_mode(i2c_mode), .o_addr_bit6(bit6),
    .o_accessory_status(acc), .o_int_pending(pend));
  port_partner port_partner_inst (
    .i_core_clk(i_core_clk), .i_present_source(pres_src), .o_cc_sense(cc_sense),
    .o_bus_power(bus_pwr), .o_rp_level(rp_lvl), .o_overcurrent(over_cur));
  // compare one value and count it
  task automatic check(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // select one observed value
  function automatic logic [7:0] probe(input int k);
    case (k)
      sup:     probe = {7'h00, supply_on};
      src:     probe = {7'h00, pres_src};
      accs:    probe = {5'h00, acc};
      pnd:     probe = {7'h00, pend};
      default: probe = {7'h00, pins[k]};
    endcase
  endfunction
  // wait a bounded number of cycles for a value, then judge it
  task automatic wait_for(input int k, input logic [7:0] v, input int lim, input string nm);
    for (int n = 0; n < lim && probe(k) !== v; n++) @(negedge i_core_clk);
    check(nm, probe(k), v);
  endtask
  // one-cycle host write pulse
  task automatic pulse(ref logic s);
    @(negedge i_core_clk);
    s = 1'b1;
    @(negedge i_core_clk);
    s = 1'b0;
  endtask
  // pass through shutdown so the straps are sampled again
  task automatic start(input typec_port_pkg::tri_level_t sel, role);
    @(negedge i_core_clk);
    en_n = 1'b1;
    repeat (3) @(negedge i_core_clk);
    sel_pin  = sel;
    role_pin = role;
    en_n     = 1'b0;
    main_ok  = 1'b1;
    repeat (3) @(negedge i_core_clk);
  endtask
  // outputs only ever pull low
  always @(negedge i_core_clk) begin
    if (i_rst_n === 1'b1) check("pin drive", {3'h0, od_o}, 8'h00);
  end
  // hang guard
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      wrap_up();
    end
  end
  // reset, then shutdown with the port disabled
  task automatic t_reset();
    repeat (6) @(negedge i_core_clk);
    check("oe_n in reset", {3'h0, oe_n}, 8'h1f);
    check("acc in reset", probe(accs), 8'h00);
    i_rst_n = 1'b1;
    repeat (5) @(negedge i_core_clk);
    check("oe_n shutdown", {3'h0, oe_n}, 8'h1f);
    check("rd in shutdown", probe(src), 8'h00);
    check("supply shutdown", probe(sup), 8'h00);
  endtask
  // gpio sink: current outputs, detach on bus loss, sink debug accessory
  task automatic t_gpio_sink();
    start(typec_port_pkg::TRI_FLOAT, typec_port_pkg::TRI_LOW);
    check("gpio mode", {7'h00, i2c_mode}, 8'h00);
    port_partner_inst.set(typec_port_pkg::TERM_RP, typec_port_pkg::TERM_OPEN, 1'b1, 2'h2);
    wait_for(cur_a, 8'h00, 3000, "high a");
    check("high b", probe(cur_b), 8'h00);
    check("sink ident", probe(ident), 8'h01);
    check("sink stays rd", probe(src), 8'h00);
    port_partner_inst.set(typec_port_pkg::TERM_RP, typec_port_pkg::TERM_OPEN, 1'b1, 2'h1);
    wait_for(cur_b, 8'h01, 50, "medium b");
    check("medium a", probe(cur_a), 8'h00);
    port_partner_inst.set(typec_port_pkg::TERM_RP, typec_port_pkg::TERM_OPEN, 1'b1, 2'h0);
    wait_for(cur_a, 8'h01, 50, "default a");
    check("default b", probe(cur_b), 8'h01);
    port_partner_inst.set(typec_port_pkg::TERM_RP, typec_port_pkg::TERM_OPEN, 1'b1, 2'h2);
    wait_for(cur_a, 8'h00, 50, "high again");
    port_partner_inst.set(typec_port_pkg::TERM_RP, typec_port_pkg::TERM_OPEN, 1'b0, 2'h2);
    wait_for(cur_a, 8'h01, 3000, "bus loss a");
    check("bus loss b", probe(cur_b), 8'h01);
    port_partner_inst.set(typec_port_pkg::TERM_RP, typec_port_pkg::TERM_RP, 1'b1, 2'h0);
    wait_for(accs, 8'h06, 3000, "sink debug");
    port_partner_inst.set(typec_port_pkg::TERM_OPEN, typec_port_pkg::TERM_OPEN, 1'b0, 2'h0);
    wait_for(accs, 8'h00, 3000, "debug gone");
  endtask
  // register mode dual role: toggling, cable supply, interrupt, fault latch
  task automatic t_i2c_src();
    start(typec_port_pkg::TRI_HIGH, typec_port_pkg::TRI_FLOAT);
    check("i2c mode", {7'h00, i2c_mode}, 8'h01);
    check("addr bit6", {7'h00, bit6}, 8'h01);
    wait_for(src, 8'h01, 1100, "toggle to rp");
    wait_for(src, 8'h00, 1100, "toggle to rd");
    check("toggle quiet", probe(pnd), 8'h00);
    check("unattached supply", probe(sup), 8'h00);
    pulse(int_clr);
    port_partner_inst.set(typec_port_pkg::TERM_RD, typec_port_pkg::TERM_RA, 1'b0, 2'h0);
    wait_for(ident, 8'h00, 3000, "source ident");
    wait_for(sup, 8'h01, 3, "supply on");
    check("supply on cc2", {7'h00, on_cc2}, 8'h01);
    wait_for(aud, 8'h00, 3, "int pin");
    check("pending set", probe(pnd), 8'h01);
    pulse(int_clr);
    wait_for(aud, 8'h01, 3, "int released");
    check("pending clear", probe(pnd), 8'h00);
    port_partner_inst.oc(1'b1);
    wait_for(sup, 8'h00, 5, "fault off");
    wait_for(flt, 8'h00, 3, "fault pin");
    check("fault pending", probe(pnd), 8'h01);
    port_partner_inst.oc(1'b0);
    repeat (20) @(negedge i_core_clk);
    check("fault holds", probe(sup), 8'h00);
    pulse(fault_clr);
    wait_for(sup, 8'h01, 5, "fault cleared");
    port_partner_inst.set(typec_port_pkg::TERM_OPEN, typec_port_pkg::TERM_OPEN, 1'b0, 2'h0);
    wait_for(ident, 8'h01, 50, "unplug ident");
    wait_for(sup, 8'h00, 5, "unplug supply");
    port_partner_inst.set(typec_port_pkg::TERM_RD, typec_port_pkg::TERM_RD, 1'b0, 2'h0);
    wait_for(accs, 8'h07, 3000, "source debug");
    port_partner_inst.set(typec_port_pkg::TERM_RD, typec_port_pkg::TERM_RA, 1'b0, 2'h0);
    wait_for(ident, 8'h00, 3000, "reattach");
    main_ok = 1'b0;
    wait_for(ident, 8'h01, 20, "supply loss");
    check("supply loss cable", probe(sup), 8'h00);
    port_partner_inst.set(typec_port_pkg::TERM_OPEN, typec_port_pkg::TERM_OPEN, 1'b0, 2'h0);
  endtask
  // gpio source only: fault lockout until reattach, audio accessory, disable
  task automatic t_gpio_src();
    start(typec_port_pkg::TRI_FLOAT, typec_port_pkg::TRI_HIGH);
    port_partner_inst.set(typec_port_pkg::TERM_RD, typec_port_pkg::TERM_RA, 1'b0, 2'h0);
    wait_for(sup, 8'h01, 3000, "gpio supply");
    port_partner_inst.oc(1'b1);
    wait_for(sup, 8'h00, 5, "gpio fault off");
    port_partner_inst.oc(1'b0);
    pulse(fault_clr);
    repeat (20) @(negedge i_core_clk);
    check("lockout", probe(sup), 8'h00);
    port_partner_inst.set(typec_port_pkg::TERM_OPEN, typec_port_pkg::TERM_OPEN, 1'b0, 2'h0);
    wait_for(ident, 8'h01, 50, "gpio detach");
    port_partner_inst.set(typec_port_pkg::TERM_RA, typec_port_pkg::TERM_RA, 1'b0, 2'h0);
    wait_for(aud, 8'h00, 3000, "audio pin");
    check("audio code", probe(accs), {5'h00, `ACC_AUDIO});
    check("audio supply", probe(sup), 8'h00);
    port_partner_inst.set(typec_port_pkg::TERM_RA, typec_port_pkg::TERM_RD, 1'b0, 2'h0);
    wait_for(sup, 8'h01, 3000, "reattach supply");
    check("supply on cc1", {7'h00, on_cc2}, 8'h00);
    @(negedge i_core_clk);
    en_n = 1'b1;
    wait_for(ident, 8'h01, 10, "disable ident");
    wait_for(sup, 8'h00, 5, "disable supply");
    check("disable rd", probe(src), 8'h00);
    port_partner_inst.set(typec_port_pkg::TERM_OPEN, typec_port_pkg::TERM_OPEN, 1'b0, 2'h0);
  endtask
  // register mode with the select pin low, sink only
  task automatic t_addr_low();
    start(typec_port_pkg::TRI_LOW, typec_port_pkg::TRI_LOW);
    check("i2c mode low", {7'h00, i2c_mode}, 8'h01);
    check("addr bit6 low", {7'h00, bit6}, 8'h00);
    repeat (1100) @(negedge i_core_clk);
    check("sink only rd", probe(src), 8'h00);
  endtask
  // verdict and end of run
  task automatic wrap_up();
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_gpio_sink();
    t_i2c_src();
    t_gpio_src();
    t_addr_low();
    wrap_up();
  end
endmodule
